/* verilog/urcs_top.v */
// Contract
// - Host command arms or disarms the manual service request feature.
// - While armed, show prompt label at the bottom soft key.
// - Bottom key press in root menu sets user request and event bit.
// - Event bit raises service request, local mode too, only if enabled.
// - Query of the feature returns its present armed state.
// - Clear-status command clears every status register incl. both here.
// - Command error read returns contents 0..13 and clears it.
// - Latest syntax error code overwrites the command error register.
// - Error codes 1-7 and 10-13 as assigned; zero and above 13 never stored.
//
// The register offsets and the Wishbone slave port were decided locally.
`default_nettype none
`include "urcs_defines.vh"

module urcs_top
(
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Front panel
  input wire soft_key_press,
  input wire root_menu_shown,
  output reg prompt_label_show,
  // Parser error report
  input wire parse_err_valid,
  input wire [3:0] parse_err_code,
  // Status outputs
  output reg user_request_event_bit,
  output reg service_request,
  output reg irq
);

  reg user_request_arm_short_reg;
  reg srq_enable_reg;
  reg user_request_register;
  reg [1:0] irq_stat_reg;
  reg [1:0] irq_mask_reg;
  reg key_d_reg;
  wire [3:0] command_error_register;
  wire req;
  wire wr;
  wire rd;
  wire key_rise;
  wire clear_all_status_cmd;
  wire cerr_rd;
  wire ureq_set;
  wire cerr_set;
  reg [31:0] rdata;

  // Register decode
  wire sel_ctrl;
  wire sel_stat;
  wire sel_mask;
  wire sel_cerr;
  wire wr_ctrl;
  wire wr_mask;
  wire rd_stat;

  // Status bit set and clear terms
  wire [1:0] stat_set;
  wire [1:0] stat_clr;
  wire [1:0] irq_stat_next;

  // Next values of the bus side
  reg ack_next;
  reg [31:0] dat_next;
  reg arm_next;
  reg srq_en_next;
  reg [1:0] mask_next;

  // Next values of the status side
  reg user_request_next;
  reg event_bit_next;

  // Next values of the outputs
  reg prompt_next;
  reg srq_next;
  reg irq_next;

  assign sel_ctrl = (wb_adr_i == `URCS_OFF_CTRL);
  assign sel_stat = (wb_adr_i == `URCS_OFF_STAT);
  assign sel_mask = (wb_adr_i == `URCS_OFF_MASK);
  assign sel_cerr = (wb_adr_i == `URCS_OFF_CERR);
  assign wr_ctrl = wr && sel_ctrl;
  assign wr_mask = wr && sel_mask;
  assign rd_stat = rd && sel_stat;

  assign stat_set = {cerr_set, ureq_set};
  // Reading status or clear-all drops every bit at once
  assign stat_clr = {2{rd_stat || clear_all_status_cmd}};

  // Accept only on a fresh request so each access acts exactly once
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign rd = req && !wb_we_i;
  assign key_rise = soft_key_press && !key_d_reg;
  // Self-clearing strobe: writing the bit issues the command
  assign clear_all_status_cmd = wr && (wb_adr_i == `URCS_OFF_CTRL) &&
                                wb_dat_i[`URCS_CTRL_CLS];
  assign cerr_rd = rd && (wb_adr_i == `URCS_OFF_CERR);
  // Press counts only when armed and the root menu is up
  assign ureq_set = key_rise && root_menu_shown && user_request_arm_short_reg;
  assign cerr_set = parse_err_valid && (parse_err_code != `URCS_ERR_NONE) &&
                    (parse_err_code <= `URCS_ERR_MAX);

  urcs_err_latch u_err
  (
    .core_clk(core_clk),
    .rst(rst),
    .err_valid(parse_err_valid),
    .err_code(parse_err_code),
    .clear_rd(cerr_rd),
    .clear_cls(clear_all_status_cmd),
    .code_reg(command_error_register)
  );

  always @*
  begin
    rdata = 32'h0000_0000;
    case (wb_adr_i)
      `URCS_OFF_CTRL:
      begin
        rdata[`URCS_CTRL_ARM] = user_request_arm_short_reg;
        rdata[`URCS_CTRL_SRQ_EN] = srq_enable_reg;
      end
      `URCS_OFF_STAT:
        rdata[1:0] = irq_stat_reg;
      `URCS_OFF_MASK:
        rdata[1:0] = irq_mask_reg;
      `URCS_OFF_CERR:
        rdata[3:0] = command_error_register;
      default:
        rdata = 32'h0000_0000;
    endcase
  end

  // Bus side next values; read data is captured only on a read
  always @*
  begin
    ack_next = req;
    dat_next = wb_dat_o;
    arm_next = user_request_arm_short_reg;
    srq_en_next = srq_enable_reg;
    mask_next = irq_mask_reg;
    if (rd)
      dat_next = rdata;
    if (wr_ctrl)
    begin
      arm_next = wb_dat_i[`URCS_CTRL_ARM];
      srq_en_next = wb_dat_i[`URCS_CTRL_SRQ_EN];
    end
    if (wr_mask)
      mask_next = wb_dat_i[1:0];
  end

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= ack_next;
      wb_dat_o <= dat_next;
    end
  end

  // Mask survives clear-all; arm and enable load from the same CTRL write that carries it
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      user_request_arm_short_reg <= 1'b0;
      srq_enable_reg <= 1'b0;
      irq_mask_reg <= `URCS_MASK_RST;
    end
    else
    begin
      user_request_arm_short_reg <= arm_next;
      srq_enable_reg <= srq_en_next;
      irq_mask_reg <= mask_next;
    end
  end

  // Key history for edge detection; idle level is low, so no false press
  always @(posedge core_clk)
  begin
    if (rst)
      key_d_reg <= 1'b0;
    else
      key_d_reg <= soft_key_press;
  end

  // Sticky status bits; set wins so an event in the clearing cycle is kept
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : g_stat
      assign irq_stat_next[i] = stat_set[i] || (irq_stat_reg[i] && !stat_clr[i]);
    end
  endgenerate

  // User request: clear first, then set, so a coincident press is never lost
  always @*
  begin
    user_request_next = user_request_register;
    event_bit_next = user_request_event_bit;
    if (clear_all_status_cmd)
    begin
      user_request_next = 1'b0;
      event_bit_next = 1'b0;
    end
    if (ureq_set)
    begin
      user_request_next = 1'b1;
      event_bit_next = 1'b1;
    end
  end

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      user_request_register <= 1'b0;
      user_request_event_bit <= 1'b0;
    end
    else
    begin
      user_request_register <= user_request_next;
      user_request_event_bit <= event_bit_next;
    end
  end

  always @(posedge core_clk)
  begin
    if (rst)
      irq_stat_reg <= 2'h0;
    else
      irq_stat_reg <= irq_stat_next;
  end

  // Outputs registered; service request follows the event bit one cycle later
  always @*
  begin
    prompt_next = user_request_arm_short_reg;
    // Raised regardless of local or remote mode
    srq_next = user_request_event_bit && srq_enable_reg;
    irq_next = |(irq_stat_reg & irq_mask_reg);
  end

  always @(posedge core_clk)
  begin
    if (rst)
      prompt_label_show <= 1'b0;
    else
      prompt_label_show <= prompt_next;
  end

  always @(posedge core_clk)
  begin
    if (rst)
      service_request <= 1'b0;
    else
      service_request <= srq_next;
  end

  always @(posedge core_clk)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= irq_next;
  end

endmodule // urcs_top
`default_nettype wire

/* verilog/urcs_defines.vh */
`ifndef URCS_DEFINES_VH
`define URCS_DEFINES_VH

// Register byte offsets
`define URCS_OFF_CTRL 4'h0
`define URCS_OFF_STAT 4'h4
`define URCS_OFF_MASK 4'h8
`define URCS_OFF_CERR 4'hc

// Control register fields
`define URCS_CTRL_ARM 0
`define URCS_CTRL_SRQ_EN 1
`define URCS_CTRL_CLS 2
`define URCS_CTRL_RST 2'h0

// Interrupt status / mask fields
`define URCS_IRQ_UREQ 0
`define URCS_IRQ_CERR 1
`define URCS_MASK_RST 2'h0

// Command error codes
`define URCS_ERR_NONE 4'h0
`define URCS_ERR_MAX 4'hd

`endif

/* verilog/urcs_err_latch.v */
`default_nettype none
`include "urcs_defines.vh"

module urcs_err_latch
(
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Parser report
  input wire err_valid,
  input wire [3:0] err_code,
  // Clearing
  input wire clear_rd,
  input wire clear_cls,
  // State
  output reg [3:0] code_reg
);

  wire code_ok;
  reg [3:0] code_next;

  // Codes outside the documented range are dropped, not stored
  assign code_ok = (err_code != `URCS_ERR_NONE) && (err_code <= `URCS_ERR_MAX);

  always @*
  begin
    code_next = code_reg;
    if (clear_rd || clear_cls)
      code_next = `URCS_ERR_NONE;
    // A new error in the clearing cycle survives the clear
    if (err_valid && code_ok)
      code_next = err_code;
  end

  always @(posedge core_clk)
  begin
    if (rst)
      code_reg <= `URCS_ERR_NONE;
    else
      code_reg <= code_next;
  end

endmodule // urcs_err_latch
`default_nettype wire

/* testbench/urcs_properties.sv */
`default_nettype none
module urcs_props (
  // Watched ports
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic soft_key_press,
  input wire logic root_menu_shown,
  input wire logic prompt_label_show,
  input wire logic user_request_event_bit,
  input wire logic service_request
);
  timeunit 1ns;
  timeprecision 1ps;
  wire ev = user_request_event_bit;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  a_ack_due: assert property (s_take |=> wb_ack_o) else $error("ack");
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack");
  a_srq_cause: assert property (service_request |-> $past(ev)) else $error("srq");
  a_srq_drop: assert property ($fell(ev) |=> !service_request) else $error("srq");
  a_key_event:
    assert property ($rose(soft_key_press) && prompt_label_show && root_menu_shown |=> ev)
      else $error("key");
  a_event_root: assert property ($rose(ev) |-> $past(root_menu_shown)) else $error("root");
  a_event_clear: assert property ($fell(ev) |-> wb_ack_o) else $error("clear");
  a_prompt_cause:
    assert property ($changed(prompt_label_show) |-> $past(wb_ack_o)) else $error("prompt");
endmodule // urcs_props
bind urcs_top urcs_props chk_u (.*);
`default_nettype wire

/* testbench/urcs_host_model.sv */
`default_nettype none
module urcs_host_model (
  // Clock and error report
  input wire logic core_clk,
  output var logic parse_err_valid,
  output var logic [3:0] parse_err_code
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
    {parse_err_valid, parse_err_code} = 5'h0;
  // Inverted code after the pulse so a stale value never looks valid
  task automatic send(logic [3:0] x);
    parse_err_valid <= 1'h1;
    parse_err_code <= x;
    @(posedge core_clk);
    parse_err_valid <= 1'h0;
    parse_err_code <= ~x;
    @(posedge core_clk);
  endtask
endmodule // urcs_host_model
`default_nettype wire

/* testbench/tb_urcs_top.sv */
`default_nettype none
module tb_urcs_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, irq;
  logic soft_key_press = 0, root_menu_shown = 0, wb_ack_o, prompt_label_show;
  logic user_request_event_bit, service_request, parse_err_valid;
  logic [3:0] wb_adr_i = 0, wb_sel_i = 4'hf, parse_err_code, c;
  logic [31:0] wb_dat_i = 0, wb_dat_o;
  int errors = 0, compares = 0;
  urcs_top dut_u (.*);
  urcs_host_model host_u (.*);
  initial
    forever #5 core_clk = ~core_clk;
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wb(logic w, logic [3:0] a, logic [31:0] d, logic [31:0] e = 0);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (int n = 0; n < 50 && wb_ack_o !== 1'h1; n++)
      @(posedge core_clk);
    if (wb_ack_o !== 1'h1)
      errors++;
    if (!w)
      chk("read", e, wb_dat_o);
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic press(logic m);
    root_menu_shown <= m;
    soft_key_press <= 1'h1;
    repeat (3) @(posedge core_clk);
    soft_key_press <= 1'h0;
    @(posedge core_clk);
  endtask
  function automatic logic [3:0] code();
    int k = $urandom % 11;
    return 4'(k < 7 ? k + 1 : k + 3);
  endfunction
  task automatic wrap_up();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #40000;
    errors++;
    wrap_up();
  end
  initial
  begin
    void'($urandom(51));
    repeat (20) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    wb(0, 4'h2, 0, 0);
    wb(1, 4'h0, 3);
    chk("prompt", 1, prompt_label_show);
    press(1);
    chk("irq", 0, irq);
    chk("srq", 1, service_request);
    wb(1, 4'h8, 3);
    chk("irq", 1, irq);
    wb(0, 4'h4, 0, 1);
    press(0);
    wb(0, 4'h4, 0, 0);
    repeat (5)
    begin
      c = code();
      host_u.send(code());
      host_u.send(c);
      host_u.send(4'he);
      wb(0, 4'hc, 0, c);
      wb(0, 4'hc, 0, 0);
    end
    host_u.send(c);
    press(1);
    wb(1, 4'h0, 7);
    wb(0, 4'hc, 0, 0);
    wb(0, 4'h4, 0, 0);
    wb(0, 4'h0, 0, 3);
    wb(1, 4'h0, 1);
    press(1);
    chk("srq", 0, service_request);
    wb(0, 4'h4, 0, 1);
    wb(1, 4'h0, 4);
    chk("prompt", 0, prompt_label_show);
    press(1);
    chk("event", 0, user_request_event_bit);
    wrap_up();
  end
endmodule // tb_urcs_top
`default_nettype wire
